// file: rtl/i2cfe_map.vh
`ifndef I2CFE_MAP_VH
`define I2CFE_MAP_VH
// Register indices on the plain port (address is a register index).
`define I2CFE_REG_CTRL 4'h0
`define I2CFE_REG_STAT 4'h1
`define I2CFE_REG_MASK 4'h2
`define I2CFE_REG_ADDR 4'h3
`define I2CFE_REG_TXD 4'h4
`define I2CFE_REG_RXD 4'h5
`define I2CFE_REG_DIV 4'h6
// Control fields.
`define I2CFE_CTRL_EN 0
`define I2CFE_CTRL_HWDEC 1
`define I2CFE_CTRL_WAKE 2
`define I2CFE_CTRL_PINSET 3
`define I2CFE_CTRL_TXRDY 4
`define I2CFE_CTRL_RXRDY 5
`define I2CFE_CTRL_RATE50 6
`define I2CFE_CTRL_RELEASE 7
// Status event bits.
`define I2CFE_ST_MATCH 0
`define I2CFE_ST_RXBYTE 1
`define I2CFE_ST_TXBYTE 2
`define I2CFE_ST_STOP 3
`define I2CFE_ST_NAKWR 4
// Reset values.
`define I2CFE_CTRL_RST 8'h00
`define I2CFE_ADDR_RST 7'h08
`define I2CFE_DIV_RST 8'h3E
// Oversampling ratios.
`define I2CFE_OVS_FAST 6'd16
`define I2CFE_OVS_SLOW 6'd32
// Timing: bus rate and clock rate used for the default divider.
`define I2CFE_CLK_HZ 100000000
`define I2CFE_BUS_HZ 100000
`define I2CFE_OVS_N 16
`endif

// file: rtl/i2cfe_top.v
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "i2cfe_map.vh"
module i2cfe_top
(
  // Clock and reset.
  input wire i_clk,
  input wire i_rstn,
  // Register port.
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Bus lines, sampled levels and open-drain drive (oe low drives low).
  input wire i_scl,
  input wire i_sda,
  output reg o_scl_o,
  output reg o_scl_oe_n,
  output reg o_sda_o,
  output reg o_sda_oe_n,
  // Events.
  output reg o_irq,
  output reg o_wake
);
  // ************************************************************
  // Registers
  // ************************************************************
  reg [7:0] ctrl;
  reg [4:0] stat;
  reg [4:0] mask;
  reg [6:0] own_addr;
  reg [7:0] txd;
  reg [7:0] rxd;
  reg [7:0] div;
  reg [7:0] div_cnt;
  reg [5:0] ovs_cnt;
  reg tick;
  reg bit_tick;
  reg scl_q;
  reg sda_q;
  reg [2:0] state;
  reg [3:0] bitn;
  reg [7:0] sh;
  reg rw;
  reg drive_sda;
  reg stretch;
  reg [4:0] ev;
  wire en = ctrl[`I2CFE_CTRL_EN];
  wire [5:0] ovs_max = ctrl[`I2CFE_CTRL_RATE50] ? `I2CFE_OVS_SLOW :
    `I2CFE_OVS_FAST;
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire start_c = scl_q & i_scl & sda_q & ~i_sda;
  wire stop_c = scl_q & i_scl & ~sda_q & i_sda;
  wire addr_hit = (sh[7:1] == own_addr);
  wire wake_ok = ctrl[`I2CFE_CTRL_WAKE] & ctrl[`I2CFE_CTRL_HWDEC];
  // The engine walks one byte frame at a time.
  // Idle waits for a start condition on the sampled lines.
  // The address state shifts in seven address bits and the direction bit.
  // The hold state keeps the clock low until software lets it go.
  // The acknowledge state keeps data low until the clock falls after an address match, but leaves it released when entered after a read byte's answer.
  // The write states take a byte and then answer it.
  // The read states shift a byte out and then look at the master's answer.
  // A stop or a new start always wins over whatever state is current.
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_AACK = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_WR = 3'd4;
  localparam S_WACK = 3'd5;
  localparam S_RD = 3'd6;
  localparam S_RACK = 3'd7;
  // ************************************************************
  // Register access
  // ************************************************************
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ctrl <= `I2CFE_CTRL_RST;
      mask <= 5'h00;
      own_addr <= `I2CFE_ADDR_RST;
      txd <= 8'hFF;
      div <= `I2CFE_DIV_RST;
      o_rdata <= 8'h00;
      stat <= 5'h00;
      o_irq <= 1'b0;
    end
    else
    begin
      // A read clears status, but a new event in the same cycle survives.
      if (i_rd && i_addr == `I2CFE_REG_STAT)
        stat <= ev;
      else
        stat <= stat | ev;
      o_irq <= |((stat | ev) & mask);
      if (i_wr)
      begin
        case (i_addr)
          `I2CFE_REG_CTRL: ctrl <= i_wdata;
          `I2CFE_REG_MASK: mask <= i_wdata[4:0];
          `I2CFE_REG_ADDR: own_addr <= i_wdata[6:0];
          `I2CFE_REG_TXD: txd <= i_wdata;
          `I2CFE_REG_DIV: div <= i_wdata;
          default: ;
        endcase
      end
      if (i_rd)
      begin
        case (i_addr)
          `I2CFE_REG_CTRL: o_rdata <= ctrl;
          `I2CFE_REG_STAT: o_rdata <= {3'h0, stat};
          `I2CFE_REG_MASK: o_rdata <= {3'h0, mask};
          `I2CFE_REG_ADDR: o_rdata <= {1'b0, own_addr};
          `I2CFE_REG_TXD: o_rdata <= txd;
          `I2CFE_REG_RXD: o_rdata <= rxd;
          `I2CFE_REG_DIV: o_rdata <= div;
          default: o_rdata <= 8'h00;
        endcase
      end
      else
        o_rdata <= 8'h00;
      // Read data stand for one cycle only, so a master that samples late
      // sees zero rather than a stale value from an older read.
    end
  end
  // ************************************************************
  // Oversampling tick
  // ************************************************************
  // The divider yields the sample tick; sixteen or thirty-two ticks make a
  // bit, so the bit period is fixed by software through the divider.
  // Lines are only looked at on a tick, which filters short glitches but
  // means that software must keep the tick well above the bus rate.
  // Disabling the block clears the sampled levels back to the idle high,
  // so no false edge is seen when it is enabled again.
  always @(posedge i_clk)
  begin
    if (!i_rstn || !en)
    begin
      div_cnt <= 8'h00;
      ovs_cnt <= 6'd0;
      tick <= 1'b0;
      bit_tick <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      tick <= (div_cnt == div);
      div_cnt <= (div_cnt == div) ? 8'h00 : div_cnt + 8'h01;
      bit_tick <= 1'b0;
      if (tick)
      begin
        scl_q <= i_scl;
        sda_q <= i_sda;
        if (ovs_cnt == ovs_max - 6'd1)
        begin
          ovs_cnt <= 6'd0;
          bit_tick <= 1'b1;
        end
        else
          ovs_cnt <= ovs_cnt + 6'd1;
      end
    end
  end
  // ************************************************************
  // Slave engine
  // ************************************************************
  always @(posedge i_clk)
  begin
    if (!i_rstn || !en)
    begin
      state <= S_IDLE;
      bitn <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      drive_sda <= 1'b0;
      stretch <= 1'b0;
      ev <= 5'h00;
      rxd <= 8'h00;
      o_wake <= 1'b0;
    end
    else
    begin
      ev <= 5'h00;
      o_wake <= 1'b0;
      if (tick && start_c)
      begin
        state <= S_ADDR;
        bitn <= 4'h0;
        drive_sda <= 1'b0;
        stretch <= 1'b0;
      end
      else if (tick && stop_c)
      begin
        // A stop ends any frame; the event is only raised when the engine is not idle,
        // so not after an address miss, a refused write or a read ended by a not-acknowledge.
        state <= S_IDLE;
        drive_sda <= 1'b0;
        stretch <= 1'b0;
        if (state != S_IDLE)
          ev[`I2CFE_ST_STOP] <= 1'b1;
      end
      else if (tick)
      begin
        case (state)
          S_IDLE: ;
          S_ADDR:
            if (scl_rise)
            begin
              sh <= {sh[6:0], i_sda};
              bitn <= bitn + 4'h1;
            end
            else if (scl_fall && bitn == 4'h8)
            begin
              rw <= sh[0];
              if (addr_hit || !ctrl[`I2CFE_CTRL_HWDEC])
              begin
                drive_sda <= 1'b1;
                stretch <= 1'b1;
                ev[`I2CFE_ST_MATCH] <= 1'b1;
                o_wake <= wake_ok & ctrl[`I2CFE_CTRL_PINSET];
                state <= S_HOLD;
              end
              else
                state <= S_IDLE;
            end
          S_HOLD:
            // Clock held low until the processor sets the release bit.
            if (ctrl[`I2CFE_CTRL_RELEASE])
            begin
              stretch <= 1'b0;
              state <= S_AACK;
            end
          S_AACK:
            // The falling clock ends the acknowledge bit; a read puts out
            // its first data bit at once, a write lets the data line go.
            if (scl_fall)
            begin
              bitn <= 4'h0;
              drive_sda <= rw & ~(ctrl[`I2CFE_CTRL_TXRDY] ? txd[7]
                : 1'b1);
              sh <= ctrl[`I2CFE_CTRL_TXRDY] ? {txd[6:0], 1'b1} : 8'hFF;
              state <= rw ? S_RD : S_WR;
            end
          S_WR:
            if (scl_rise)
            begin
              sh <= {sh[6:0], i_sda};
              bitn <= bitn + 4'h1;
            end
            else if (scl_fall && bitn == 4'h8)
            begin
              if (ctrl[`I2CFE_CTRL_RXRDY])
              begin
                drive_sda <= 1'b1;
                rxd <= sh;
                ev[`I2CFE_ST_RXBYTE] <= 1'b1;
              end
              else
                ev[`I2CFE_ST_NAKWR] <= 1'b1;
              state <= S_WACK;
            end
          S_WACK:
            // Without a receive buffer the frame is dropped after the
            // not-acknowledge, since nothing more can be stored.
            if (scl_fall)
            begin
              drive_sda <= 1'b0;
              bitn <= 4'h0;
              state <= ctrl[`I2CFE_CTRL_RXRDY] ? S_WR : S_IDLE;
            end
          S_RD:
            // Each falling clock moves the next bit out; after the eighth
            // the line is released so the master can answer.
            if (scl_fall)
            begin
              bitn <= bitn + 4'h1;
              if (bitn == 4'h7)
              begin
                drive_sda <= 1'b0;
                state <= S_RACK;
                ev[`I2CFE_ST_TXBYTE] <= 1'b1;
              end
              else
              begin
                drive_sda <= ~sh[7];
                sh <= {sh[6:0], 1'b1};
              end
            end
          S_RACK:
            // A high line means the master wants no more bytes.
            if (scl_rise)
              state <= i_sda ? S_IDLE : S_AACK;
          default: state <= S_IDLE;
        endcase
      end
    end
  end
  // ************************************************************
  // Line drivers
  // ************************************************************
  // Split output and enable let an outside multiplexer own the pads.
  // The output value is always low when driving but high when released, so a pad wired
  // without its enable would push a line high against another party.
  // The enable is taken straight from the block enable as well, so a
  // disable frees both lines on the next cycle even mid-frame.
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_scl_o <= 1'b1;
      o_scl_oe_n <= 1'b1;
      o_sda_o <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      o_scl_o <= ~(en & stretch);
      o_scl_oe_n <= ~(en & stretch);
      o_sda_o <= ~(en & drive_sda);
      o_sda_oe_n <= ~(en & drive_sda);
    end
  end
endmodule
`default_nettype wire

// file: verif/i2cfe_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cfe_map.vh"
module i2cfe_asserts
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [7:0] o_rdata,
  // Line drive and events.
  input wire logic o_scl_o,
  input wire logic o_scl_oe_n,
  input wire logic o_sda_o,
  input wire logic o_sda_oe_n,
  input wire logic o_irq,
  input wire logic o_wake
);
  logic [7:0] ctrl;
  logic [7:0] mask;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ****
  // Shadows of what software wrote, to tie outputs back to settings.
  // ****
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ctrl <= 8'h00;
      mask <= 8'h00;
    end
    else if (i_wr && i_addr == `I2CFE_REG_CTRL)
      ctrl <= i_wdata;
    else if (i_wr && i_addr == `I2CFE_REG_MASK)
      mask <= i_wdata;
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_rstn |=> o_scl_oe_n && o_sda_oe_n && !o_irq && !o_wake
    && o_rdata == 8'h00) else $error("active output in reset");
  a_sda_drive_low: assert property (!o_sda_oe_n |-> !o_sda_o)
    else $error("sda driven high");
  a_scl_drive_low: assert property (!o_scl_oe_n |-> !o_scl_o)
    else $error("scl driven high");
  a_wake_gated: assert property (
    o_wake |-> $past(ctrl[3:1]) == 3'h7) else $error("wake not gated");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake longer than a cycle");
  a_drive_enabled: assert property (
    !o_scl_oe_n || !o_sda_oe_n |-> $past(ctrl[0]))
    else $error("line driven while disabled");
  a_disable_release: assert property (
    i_wr && i_addr == `I2CFE_REG_CTRL && !i_wdata[0]
    |-> ##2 o_scl_oe_n && o_sda_oe_n) else $error("line not released");
  a_irq_masked: assert property (o_irq |-> $past(mask) != 8'h00)
    else $error("irq with all masked");
endmodule
`default_nettype wire

// file: verif/i2cfe_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cfe_master_model
(
  // Clock.
  input wire logic i_clk,
  // Device drive of both lines.
  input wire logic i_scl_o,
  input wire logic i_scl_oe_n,
  input wire logic i_sda_o,
  input wire logic i_sda_oe_n,
  // Resolved line levels.
  output wire logic o_scl,
  output wire logic o_sda
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  // Pull-ups hold a released line high; any party pulling low wins.
  assign o_scl = m_scl & (i_scl_oe_n | i_scl_o);
  assign o_sda = m_sda & (i_sda_oe_n | i_sda_o);
  // Half a bit is eight sample ticks at a divider of three.
  task automatic half();
    repeat (32) @(posedge i_clk);
  endtask
  // The slave may stretch the low phase, so the wait is bounded.
  task automatic bit_x(input logic b, output logic s);
    m_sda <= b;
    half();
    m_scl <= 1'b1;
    for (int n = 0; n < 5000 && o_scl !== 1'b1; n++) @(posedge i_clk);
    half();
    s = o_sda;
    m_scl <= 1'b0;
  endtask
  task automatic start();
    m_sda <= 1'b1;
    m_scl <= 1'b1;
    half();
    m_sda <= 1'b0;
    half();
    m_scl <= 1'b0;
  endtask
  task automatic stop();
    m_sda <= 1'b0;
    half();
    m_scl <= 1'b1;
    half();
    m_sda <= 1'b1;
    half();
  endtask
  // Data goes out first bit highest; the ninth bit is left released.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// file: verif/i2cfe_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cfe_map.vh"
module i2cfe_tb;
  logic i_clk;
  logic i_rstn;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  wire [7:0] o_rdata;
  wire scl;
  wire sda;
  wire scl_o;
  wire scl_oe_n;
  wire sda_o;
  wire sda_oe_n;
  wire o_irq;
  wire o_wake;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int wakes = 0;
  logic [7:0] q;
  logic ack;
  i2cfe_top u_i2cfe_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_scl(scl), .i_sda(sda), .o_scl_o(scl_o), .o_scl_oe_n(scl_oe_n),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .o_irq(o_irq), .o_wake(o_wake));
  i2cfe_master_model u_i2cfe_master_model (.i_clk(i_clk), .i_scl_o(scl_o),
    .i_scl_oe_n(scl_oe_n), .i_sda_o(sda_o), .i_sda_oe_n(sda_oe_n),
    .o_scl(scl), .o_sda(sda));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hung handshake must still reach the closing report.
  always @(posedge i_clk)
  begin
    cycles++;
    if (o_wake === 1'b1)
      wakes++;
    if (cycles == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: bit %b want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp8(d, e);
  endtask
  task automatic mx(input logic [7:0] d, input logic e);
    u_i2cfe_master_model.xfer(d, q, ack);
    cmp1(ack, e);
  endtask
  // Software side: wait for the match, see the stretch, then answer.
  task automatic serve(input logic [7:0] c);
    logic [7:0] d;
    for (int n = 0; n < 5000 && o_irq !== 1'b1; n++) @(posedge i_clk);
    repeat (100) @(posedge i_clk);
    cmp1(scl, 1'b0);
    rd(`I2CFE_REG_STAT, d);
    cmp1(d[0], 1'b1);
    wr(`I2CFE_REG_CTRL, c);
  endtask
  initial
  begin
    i_rstn = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdc(`I2CFE_REG_CTRL, 8'h00);
    rdc(`I2CFE_REG_ADDR, 8'h08);
    rdc(`I2CFE_REG_DIV, 8'h3E);
    rdc(4'hF, 8'h00);
    wr(`I2CFE_REG_DIV, 8'h03);
    wr(`I2CFE_REG_MASK, 8'h1F);
    wr(`I2CFE_REG_TXD, 8'h3C);
    wr(`I2CFE_REG_CTRL, 8'h03);
    u_i2cfe_master_model.start();
    mx(8'h12, 1'b0);
    u_i2cfe_master_model.stop();
    rdc(`I2CFE_REG_STAT, 8'h00);
    cmp1(o_irq, 1'b0);
    fork
      begin
        u_i2cfe_master_model.start();
        mx(8'h10, 1'b1);
        mx(8'h5A, 1'b0);
        u_i2cfe_master_model.stop();
      end
      serve(8'h83);
    join
    rd(`I2CFE_REG_STAT, q);
    cmp1(q[4], 1'b1);
    wr(`I2CFE_REG_CTRL, 8'h03);
    fork
      begin
        u_i2cfe_master_model.start();
        mx(8'h11, 1'b1);
        mx(8'hFF, 1'b0);
        cmp8(q, 8'hFF);
        u_i2cfe_master_model.stop();
      end
      serve(8'h83);
    join
    cmp1(wakes == 0, 1'b1);
    rd(`I2CFE_REG_STAT, q);
    cmp1(q[2], 1'b1);
    wr(`I2CFE_REG_CTRL, 8'h0F);
    fork
      begin
        u_i2cfe_master_model.start();
        mx(8'h10, 1'b0);
      end
      serve(8'h00);
    join
    repeat (3) @(posedge i_clk);
    cmp1(scl_oe_n, 1'b1);
    cmp1(sda_oe_n, 1'b1);
    cmp1(wakes == 1, 1'b1);
    u_i2cfe_master_model.stop();
    report_and_stop();
  end
endmodule
bind i2cfe_top i2cfe_asserts u_i2cfe_asserts (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .o_rdata(o_rdata), .o_scl_o(o_scl_o), .o_scl_oe_n(o_scl_oe_n),
  .o_sda_o(o_sda_o), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq),
  .o_wake(o_wake));
`default_nettype wire
